// file: include/ubsp_pkg.sv
// constants and types shared by the mcu serial port
package ubsp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_HZ = 10_000_000;
    localparam int RST_MIN_NS = 20_000;
    localparam int RST_MIN_CYC =
        (RST_MIN_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
    localparam int RATE0_HZ = 1_500_000;
    localparam int RATE1_HZ = 2_000_000;
    localparam int RATE2_HZ = 3_000_000;
    localparam int RATE3_HZ = 6_000_000;

    function automatic int atLeastOne(input int v);
        return (v < 1) ? 1 : v;
    endfunction

    // half periods of the mcu clock, rounded down, never below one
    localparam int HALF0_CYC = atLeastOne(SYS_HZ / (2 * RATE0_HZ));
    localparam int HALF1_CYC = atLeastOne(SYS_HZ / (2 * RATE1_HZ));
    localparam int HALF2_CYC = atLeastOne(SYS_HZ / (2 * RATE2_HZ));
    localparam int HALF3_CYC = atLeastOne(SYS_HZ / (2 * RATE3_HZ));
    localparam int DIV_W = 8;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // status layout
    // ------------------------------------------------------------
    localparam int SB_OUT_DONE = 0;
    localparam int SB_EP0_IN = 1;
    localparam int SB_EP12_IN = 2;
    localparam int SB_EXT_LO = 3;
    localparam int SB_EXT_W = 3;
    localparam int SB_USB_RST = 6;
    localparam int SB_HW_RST = 7;
    localparam logic [7:0] STATUS_RST = 8'h80;

    // ------------------------------------------------------------
    // address/count byte and configuration
    // ------------------------------------------------------------
    localparam int ADDR_LSB = 5;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_EP0_FIFO = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_EP12_FIFO = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_BRIDGE_CFG = 3'h7;
    localparam int CFG_W = 7;

    // ------------------------------------------------------------
    // synchroniser slots
    // ------------------------------------------------------------
    localparam int SY_SCK = 0;
    localparam int SY_DIR = 1;
    localparam int SY_SDI = 2;
    localparam int SY_WAKE = 3;
    localparam int SY_RSTN = 4;
    localparam int SY_VLOW = 5;
    localparam int SY_N = 6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STATUS = 2'b01,
        ST_COUNT = 2'b10,
        ST_IN = 2'b11
    } ubsp_state_type;

    typedef struct packed {
        logic staticClk;
        logic forceResume;
        logic suspend;
        logic stopOsc;
        logic stopMcuClk;
        logic [1:0] clockRateField;
    } ubsp_cfg_type;

    localparam ubsp_cfg_type CFG_RST = 7'h00;

    typedef struct packed {
        logic outDoneSet;
        logic ep0InDoneSet;
        logic ep12InDoneSet;
    } ubsp_evt_type;

endpackage

// file: verilog/ubsp_serial_port.sv
// microcontroller-side serial port of the usb bridge
// What this block does
// - new out bit shown while link clock low
// - direction low sends data to the mcu
// - direction rise ends read, clears out-complete
// - direction fall ends write, clears in-complete
// - direction rise starts write, address byte first
// - one input pulse loads status, lsb first
// - two input pulses load out byte count
// - idle output shows status bit zero
// - direction high gives active-low interrupt nor
// - latch set on completion edges, cleared by read
// - reset output low for every reset source
// - hardware and usb reset flags in status
// - reset input holds output minimum time
// - low bus voltage holds output minimum time
// - usb reset gives fixed pulse, flag cleared
// - wake clears stop oscillator and clock bits
// - wake while stopped raises idle interrupt
// - configuration applied after write transfer ends
// - mcu clock at one of three rates; rate fields 2 and 3 give the same
module ubsp_serial_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic directionFrameLine,
    input wire logic serialInLine,
    output logic serialOutLine,
    output logic mcuClockOut,
    output logic resetOutNOut,
    output logic resetOutNOe,
    input wire logic resetInN,
    input wire logic busLowIn,
    input wire logic wakeLine,
    input wire logic usbReset,
    input wire logic resumeSig,
    input wire ubsp_pkg::ubsp_evt_type events,
    input wire logic [ubsp_pkg::SB_EXT_W-1:0] extStatus,
    input wire logic [7:0] outByteCount,
    input wire logic [7:0] outFifoData,
    output logic outFifoPop,
    output logic [7:0] inAddrCount,
    output logic [7:0] inByte,
    output logic inByteValid,
    output ubsp_pkg::ubsp_cfg_type cfgOut,
    output logic oscRestart
);
    import ubsp_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SY_N-1:0] rawIn;
    logic [SY_N-1:0] sync1Q;
    logic [SY_N-1:0] sync2Q;
    logic [SY_N-1:0] prevQ;
    logic [SY_N-1:0] riseV;
    logic [SY_N-1:0] fallV;

    assign rawIn = {busLowIn, resetInN, wakeLine, serialInLine,
                    directionFrameLine, serialClk};

    genvar gi;
    generate
        for (gi = 0; gi < SY_N; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1Q[gi] <= 1'b0;
                    sync2Q[gi] <= 1'b0;
                    prevQ[gi] <= 1'b0;
                end else begin
                    sync1Q[gi] <= rawIn[gi];
                    sync2Q[gi] <= sync1Q[gi];
                    prevQ[gi] <= sync2Q[gi];
                end
            end
        end
    endgenerate

    assign riseV = sync2Q & ~prevQ;
    assign fallV = ~sync2Q & prevQ;

    wire dirLvl = sync2Q[SY_DIR];
    wire sdiLvl = sync2Q[SY_SDI];
    wire dirRise = riseV[SY_DIR];
    wire dirFall = fallV[SY_DIR];
    wire sdiFall = fallV[SY_SDI];
    wire sckFall = fallV[SY_SCK];
    wire wakeRise = riseV[SY_WAKE];
    // pin reset held low or bus voltage low
    wire hwActive = ~sync2Q[SY_RSTN] | sync2Q[SY_VLOW];

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    ubsp_state_type stateQ, stateD;
    logic [2:0] bitCntQ;
    logic [7:0] outShiftQ;
    logic [7:0] inShiftQ;
    logic firstByteQ;
    logic sckSeenQ;
    logic [7:0] statusQ;
    logic [2:0] flagPrevQ;
    logic intLatchQ;
    logic wakeIntQ;
    ubsp_cfg_type cfgQ;
    ubsp_cfg_type cfgNextQ;
    logic cfgPendQ;
    logic sdoQ;

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ST_IDLE: begin
                if (dirRise)
                    stateD = ST_IN;
                else if (!dirLvl && sdiFall)
                    stateD = ST_STATUS;
            end
            ST_STATUS: begin
                if (dirRise)
                    stateD = ST_IN;
                else if (sdiFall && !sckSeenQ)
                    stateD = ST_COUNT;
            end
            ST_COUNT: begin
                if (dirRise)
                    stateD = ST_IN;
            end
            ST_IN: begin
                if (dirFall)
                    stateD = ST_IDLE;
            end
        endcase
    end

    // single pulse from idle reads status
    wire statusRead = stateQ == ST_IDLE && !dirLvl && sdiFall;
    // second pulse before any clock selects count
    wire countLoad = stateQ == ST_STATUS && sdiFall && !sckSeenQ;
    wire outMode = stateQ == ST_STATUS || stateQ == ST_COUNT;
    // next bit moved onto the output at clock fall
    wire shiftOut = outMode && sckFall && !sdiFall;
    // mcu bit taken at the falling clock edge
    wire shiftIn = stateQ == ST_IN && sckFall;
    wire byteEnd = bitCntQ == 3'h7;
    wire [7:0] inWord = {sdiLvl, inShiftQ[7:1]};
    wire [ADDR_W-1:0] addrSel = inAddrCount[ADDR_LSB +: ADDR_W];
    wire inEnd = stateQ == ST_IN && dirFall;
    wire outEnd = dirRise && stateQ != ST_IN;
    wire usbRise = usbReset & ~statusQ[SB_USB_RST];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            stateQ <= ST_IDLE;
        else
            stateQ <= stateD;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCntQ <= 3'h0;
            outShiftQ <= 8'h00;
            sckSeenQ <= 1'b0;
        end else if (dirRise || statusRead || countLoad) begin
            bitCntQ <= 3'h0;
            outShiftQ <= countLoad ? outByteCount : statusQ;
            sckSeenQ <= 1'b0;
        end else if (shiftOut || shiftIn) begin
            bitCntQ <= bitCntQ + 3'h1;
            sckSeenQ <= 1'b1;
            if (byteEnd)
                outShiftQ <= (stateQ == ST_COUNT) ? outFifoData : 8'h00;
            else
                outShiftQ <= {1'b0, outShiftQ[7:1]};
        end
    end

    // count byte finished: the mcu now reads fifo bytes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            outFifoPop <= 1'b0;
        else
            outFifoPop <= shiftOut && byteEnd && stateQ == ST_COUNT;
    end

    // first byte after the rising edge is the address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inShiftQ <= 8'h00;
            firstByteQ <= 1'b0;
            inAddrCount <= 8'h00;
            inByte <= 8'h00;
            inByteValid <= 1'b0;
            cfgNextQ <= CFG_RST;
            cfgPendQ <= 1'b0;
        end else begin
            inByteValid <= 1'b0;
            if (dirRise) begin
                firstByteQ <= 1'b1;
                cfgPendQ <= 1'b0;
            end else if (shiftIn) begin
                inShiftQ <= inWord;
                if (byteEnd && firstByteQ) begin
                    inAddrCount <= inWord;
                    firstByteQ <= 1'b0;
                end else if (byteEnd) begin
                    inByte <= inWord;
                    inByteValid <= 1'b1;
                    if (addrSel == ADDR_BRIDGE_CFG) begin
                        cfgNextQ <= ubsp_cfg_type'(inWord[CFG_W-1:0]);
                        cfgPendQ <= 1'b1;
                    end
                end
            end else if (inEnd) begin
                cfgPendQ <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status, interrupt latch and wake
    // ------------------------------------------------------------
    logic [7:0] statusD;
    // framing pulse with no address byte has no destination
    wire addrKnown = inEnd && !firstByteQ;
    wire clrEp0 = addrKnown && addrSel == ADDR_EP0_FIFO;
    wire clrEp12 = addrKnown && addrSel == ADDR_EP12_FIFO;
    // rising edge of any completion flag
    wire latchSet = |(statusQ[2:0] & ~flagPrevQ);
    wire wakeStopped = wakeRise && (cfgQ.stopOsc || cfgQ.stopMcuClk);

    // setting always beats a clear in the same cycle
    always_comb begin
        statusD = statusQ;
        statusD[SB_OUT_DONE] = events.outDoneSet
            | (statusQ[SB_OUT_DONE] & ~outEnd);
        statusD[SB_EP0_IN] = events.ep0InDoneSet
            | (statusQ[SB_EP0_IN] & ~clrEp0);
        statusD[SB_EP12_IN] = events.ep12InDoneSet
            | (statusQ[SB_EP12_IN] & ~clrEp12);
        statusD[SB_EXT_LO +: SB_EXT_W] = extStatus;
        // cause flags; usb flag drops at end
        statusD[SB_USB_RST] = usbReset;
        statusD[SB_HW_RST] = hwActive
            | (statusQ[SB_HW_RST] & ~statusRead);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statusQ <= STATUS_RST;
            flagPrevQ <= 3'h0;
            intLatchQ <= 1'b0;
            wakeIntQ <= 1'b0;
        end else begin
            statusQ <= statusD;
            flagPrevQ <= statusQ[2:0];
            intLatchQ <= latchSet | (intLatchQ & ~statusRead);
            // wake during stop flagged until status read
            wakeIntQ <= wakeStopped | (wakeIntQ & ~statusRead);
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    // active-low interrupt while direction is high
    wire intN = ~(resumeSig | usbReset | intLatchQ);
    // idle shows status bit zero unless a wake is pending
    wire idleBit = wakeIntQ ? 1'b0 : statusQ[SB_OUT_DONE];
    // direction low carries data toward the mcu
    wire lowBit = (stateQ == ST_IDLE) ? idleBit : outShiftQ[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            sdoQ <= 1'b1;
        else
            sdoQ <= dirLvl ? intN : lowBit;
    end
    assign serialOutLine = sdoQ;

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgQ <= CFG_RST;
        end else if (hwActive) begin
            cfgQ <= CFG_RST;
        end else if (wakeRise) begin
            // wake restarts the oscillator, clears stops
            cfgQ.stopOsc <= 1'b0;
            cfgQ.stopMcuClk <= 1'b0;
        end else if (inEnd && cfgPendQ) begin
            // applied only once the write has ended
            cfgQ <= cfgNextQ;
            cfgQ.stopMcuClk <= cfgNextQ.stopMcuClk | cfgNextQ.stopOsc;
        end
    end
    assign cfgOut = cfgQ;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            oscRestart <= 1'b0;
        else
            oscRestart <= wakeRise;
    end

    // ------------------------------------------------------------
    // reset output
    // ------------------------------------------------------------
    logic [CNT_W-1:0] rstCntQ;
    wire rstLoad = hwActive | usbRise;

    // every source drives the open-drain output low
    // pin and voltage hold while active, then minimum
    // usb reset loads the counter once, no extension
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstCntQ <= CNT_W'(RST_MIN_CYC);
            resetOutNOe <= 1'b1;
        end else begin
            resetOutNOe <= rstLoad | (rstCntQ > CNT_W'(1));
            if (rstLoad)
                rstCntQ <= CNT_W'(RST_MIN_CYC);
            else if (rstCntQ != '0)
                rstCntQ <= rstCntQ - CNT_W'(1);
        end
    end
    assign resetOutNOut = 1'b0;

    // ------------------------------------------------------------
    // mcu clock
    // ------------------------------------------------------------
    logic [DIV_W-1:0] divCntQ;
    logic clkQ;
    logic [DIV_W-1:0] halfSel;

    // rate field picks the half period
    // limitation: 10 MHz source misses all four rates; fields 2 and 3 both give 5 MHz
    assign halfSel = (cfgQ.clockRateField == 2'h0) ? DIV_W'(HALF0_CYC) :
                     (cfgQ.clockRateField == 2'h1) ? DIV_W'(HALF1_CYC) :
                     (cfgQ.clockRateField == 2'h2) ? DIV_W'(HALF2_CYC) :
                                                     DIV_W'(HALF3_CYC);
    wire clkStatic = cfgQ.staticClk | cfgQ.stopMcuClk;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCntQ <= '0;
            clkQ <= 1'b0;
            mcuClockOut <= 1'b0;
        end else begin
            if (divCntQ >= halfSel - DIV_W'(1)) begin
                divCntQ <= '0;
                clkQ <= ~clkQ;
            end else begin
                divCntQ <= divCntQ + DIV_W'(1);
            end
            mcuClockOut <= clkStatic ?
                (cfgQ.staticClk & cfgQ.stopMcuClk) : clkQ;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_idle_sdo_bit0: assert property (
        !dirLvl && stateQ == ST_IDLE && !wakeIntQ
        |=> serialOutLine == $past(statusQ[SB_OUT_DONE]))
        else $error("idle output is not status bit zero");
    a_int_nor_out: assert property (
        dirLvl |=> serialOutLine == $past(intN))
        else $error("interrupt output wrong with direction high");
    a_out_clear: assert property (
        outEnd && !events.outDoneSet |=> !statusQ[SB_OUT_DONE])
        else $error("out-complete not cleared at read end");
    a_in_clear: assert property (
        clrEp0 && !events.ep0InDoneSet |=> !statusQ[SB_EP0_IN])
        else $error("ep0 in-complete not cleared");
    a_latch_set: assert property (
        latchSet && !statusRead |=> intLatchQ ##1 !serialOutLine || !dirLvl)
        else $error("interrupt latch not set by completion");
    a_status_load: assert property (
        statusRead |=> stateQ == ST_STATUS && outShiftQ == $past(statusQ))
        else $error("status not loaded by single pulse");
    a_count_load: assert property (
        countLoad |=> stateQ == ST_COUNT
        && outShiftQ == $past(outByteCount))
        else $error("count not loaded by second pulse");
    a_reset_hold: assert property (
        $fell(hwActive) |=> resetOutNOe [*8])
        else $error("reset output released too early");
    a_usb_reset_out: assert property (
        $rose(usbReset) |=> resetOutNOe)
        else $error("usb reset did not assert reset output");
    a_usb_flag: assert property (
        $fell(usbReset) |=> !statusQ[SB_USB_RST])
        else $error("usb reset flag not cleared at end");
    a_wake_clear: assert property (
        wakeRise && !hwActive |=> !cfgQ.stopOsc && !cfgQ.stopMcuClk)
        else $error("wake did not clear stop bits");
    a_wake_int: assert property (
        wakeStopped |=> wakeIntQ)
        else $error("wake while stopped raised no interrupt");
    a_cfg_defer: assert property (
        stateQ == ST_IN && !dirFall && !wakeRise && !hwActive
        |=> $stable(cfgQ))
        else $error("configuration changed during write");

endmodule // ubsp_serial_port

// file: tb/ubsp_mcu_model.sv
// microcontroller model that drives the serial control link
module ubsp_mcu_model (
    input wire logic sys_clk,
    output logic serialClk,
    output logic directionFrameLine,
    output logic serialInLine,
    input wire logic serialOutLine,
    output logic [7:0] rxByte,
    output logic rxValid
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HP = 400;
    logic dummy;

    // link clock stands low outside frames, as the pulldown leaves it
    initial begin
        serialClk = 1'b0;
        directionFrameLine = 1'b0;
        serialInLine = 1'b0;
        rxByte = 8'h00;
        rxValid = 1'b0;
    end

    // --------------------------------------------------------------
    // link cycles
    // --------------------------------------------------------------
    // output bit taken late in the high phase, just before the fall
    task automatic clockBit(input logic din, output logic dout);
        // bit changes with the rising clock edge
        #HP serialClk = 1'b1;
        serialInLine = din;
        #HP dout = serialOutLine;
        serialClk = 1'b0;
    endtask

    task automatic readFrame(input int pulses, input int nBytes);
        logic [7:0] b;
        @(posedge sys_clk) #2;
        repeat (pulses) begin
            serialInLine = 1'b1;
            #HP serialInLine = 1'b0;
            #HP;
        end
        #(2*HP);
        repeat (nBytes) begin
            for (int i = 0; i < 8; i++) clockBit(1'b0, b[i]);
            rxByte = b;
            rxValid = 1'b1;
            #HP rxValid = 1'b0;
        end
        directionFrameLine = 1'b1;
        #(2*HP) directionFrameLine = 1'b0;
        #(2*HP);
    endtask

    task automatic writeFrame(input logic [15:0] d, input int nBytes);
        @(posedge sys_clk) #2;
        directionFrameLine = 1'b1;
        #(2*HP);
        for (int i = 0; i < 8 * nBytes; i++) clockBit(d[i], dummy);
        #HP serialInLine = 1'b0;
        #HP directionFrameLine = 1'b0;
        #(2*HP);
    endtask

    task automatic setDir(input logic v);
        @(posedge sys_clk) #2;
        directionFrameLine = v;
        #(2*HP);
    endtask
endmodule // ubsp_mcu_model

// file: tb/tb_top.sv
// self-checking bench for the mcu serial port
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ubsp_pkg::*;
    localparam int LIMIT = 20000;
    logic sys_clk, rst_n, resetInN, busLowIn, wakeLine, usbReset, resumeSig;
    logic serialClk, directionFrameLine, serialInLine, serialOutLine;
    logic mcuClockOut, resetOutNOut, resetOutNOe, outFifoPop, inByteValid;
    logic oscRestart, rxValid, oscSeen;
    logic [2:0] extStatus;
    logic [7:0] outByteCount, outFifoData, inAddrCount, inByte, rxByte, v;
    ubsp_evt_type events;
    ubsp_cfg_type cfgOut;
    logic [7:0] expIn[$];
    logic [15:0] expRd[$];
    int failures = 0, checks = 0, cycles = 0, pops = 0, len, lo, hi, hold;
    int seed = 32'hC89F3D51;
    int halves[4] = '{HALF0_CYC, HALF1_CYC, HALF2_CYC, HALF3_CYC};

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ubsp_serial_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .serialClk(serialClk), .directionFrameLine(directionFrameLine),
        .serialInLine(serialInLine), .serialOutLine(serialOutLine),
        .mcuClockOut(mcuClockOut), .resetOutNOut(resetOutNOut),
        .resetOutNOe(resetOutNOe), .resetInN(resetInN), .busLowIn(busLowIn),
        .wakeLine(wakeLine), .usbReset(usbReset), .resumeSig(resumeSig),
        .events(events), .extStatus(extStatus), .outByteCount(outByteCount),
        .outFifoData(outFifoData), .outFifoPop(outFifoPop),
        .inAddrCount(inAddrCount), .inByte(inByte),
        .inByteValid(inByteValid), .cfgOut(cfgOut), .oscRestart(oscRestart));

    ubsp_mcu_model u_mcu (.sys_clk(sys_clk), .serialClk(serialClk),
        .directionFrameLine(directionFrameLine),
        .serialInLine(serialInLine), .serialOutLine(serialOutLine),
        .rxByte(rxByte), .rxValid(rxValid));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic pulse(input logic [2:0] e);
        events = ubsp_evt_type'(e);
        tick(1);
        events = '0;
        tick(6);
    endtask

    function automatic logic [7:0] st(input logic [7:0] b);
        return b | {2'b00, extStatus, 3'b000};
    endfunction

    // bounded so a stuck reset output cannot hang the run
    task automatic oeSpan(output int n);
        n = 0;
        while (resetOutNOe === 1'b1 && n < 2000) begin n++; tick(1); end
    endtask

    task automatic halfPeriod(output int n);
        logic p;
        p = mcuClockOut;
        n = 0;
        while (mcuClockOut === p && n < 20) begin n++; tick(1); end
        p = mcuClockOut;
        n = 0;
        while (mcuClockOut === p && n < 20) begin n++; tick(1); end
    endtask

    task automatic setSrc(input int s, input logic a);
        case (s)
            0: resetInN = ~a;
            1: busLowIn = a;
            default: usbReset = a;
        endcase
    endtask

    // --------------------------------------------------------------
    // monitors
    // --------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (inByteValid === 1'b1) check("inByte", inByte, expIn.pop_front());
        if (outFifoPop === 1'b1) pops++;
        if (oscRestart === 1'b1) oscSeen = 1'b1;
        if (cycles == LIMIT) begin failures++; tally_and_finish(); end
    end

    always @(posedge rxValid) begin
        check("rxByte", rxByte & expRd[0][15:8], expRd[0][7:0]);
        void'(expRd.pop_front());
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        resetInN = 1'b1;
        busLowIn = 1'b0;
        wakeLine = 1'b0;
        usbReset = 1'b0;
        resumeSig = 1'b0;
        events = '0;
        oscSeen = 1'b0;
        extStatus = 3'($random(seed));
        outByteCount = 8'h00;
        outFifoData = 8'h00;
        tick(3);
        rst_n = 1'b1;
        oeSpan(len);
        check("porSpan", 8'(len >= RST_MIN_CYC - 4), 8'h01);
        check("odLevel", 8'(resetOutNOut), 8'h00);
        check("idle0", 8'(serialOutLine), 8'h00);
        pulse(3'h4);
        check("idle1", 8'(serialOutLine), 8'h01);
        pulse(3'h2);
        expRd.push_back({8'hFF, st(8'h83)});
        u_mcu.readFrame(1, 1);
        expRd.push_back({8'hFF, st(8'h02)});
        u_mcu.readFrame(1, 1);
        u_mcu.setDir(1'b1);
        check("intIdle", 8'(serialOutLine), 8'h01);
        resumeSig = 1'b1;
        tick(3);
        check("intResume", 8'(serialOutLine), 8'h00);
        resumeSig = 1'b0;
        pulse(3'h1);
        check("intLatch", 8'(serialOutLine), 8'h00);
        u_mcu.setDir(1'b0);
        expRd.push_back({8'hFF, st(8'h06)});
        u_mcu.readFrame(1, 1);
        u_mcu.setDir(1'b1);
        check("intClear", 8'(serialOutLine), 8'h01);
        u_mcu.setDir(1'b0);
        outByteCount = 8'($random(seed));
        outFifoData = 8'($random(seed));
        expRd.push_back({8'hFF, outByteCount});
        expRd.push_back({8'hFF, outFifoData});
        u_mcu.readFrame(2, 2);
        check("pops", 8'(pops > 0), 8'h01);
        v = 8'($random(seed));
        expIn.push_back(v);
        u_mcu.writeFrame({v, 8'h20}, 2);
        check("addr", inAddrCount, 8'h20);
        expRd.push_back({8'hFF, st(8'h04)});
        u_mcu.readFrame(1, 1);
        expIn.push_back(v);
        u_mcu.writeFrame({v, 8'h40}, 2);
        expRd.push_back({8'hFF, st(8'h00)});
        u_mcu.readFrame(1, 1);
        for (int r = 0; r < 4; r++) begin
            expIn.push_back(8'(r));
            u_mcu.writeFrame({8'(r), 8'hE0}, 2);
            check("rate", {1'b0, cfgOut}, 8'(r));
            halfPeriod(len);
            check("half", 8'(len), 8'(halves[r]));
        end
        for (int s = 0; s < 6; s++) begin
            hold = (s < 3) ? 5 : 300;
            lo = (s % 3 == 2 || hold < RST_MIN_CYC) ? RST_MIN_CYC : hold;
            hi = (s % 3 == 2) ? RST_MIN_CYC : hold + RST_MIN_CYC;
            setSrc(s % 3, 1'b1);
            fork
                begin tick(hold); setSrc(s % 3, 1'b0); end
                begin tick(4); oeSpan(len); end
            join
            check("rstSpan", 8'(len >= lo - 6 && len <= hi + 6), 8'h01);
            tick(10);
        end
        expRd.push_back({8'hC0, 8'h80});
        u_mcu.readFrame(1, 1);
        expIn.push_back(8'h08);
        u_mcu.writeFrame({8'h08, 8'hE0}, 2);
        check("stop", {1'b0, cfgOut}, 8'h0C);
        pulse(3'h4);
        check("idleSet", 8'(serialOutLine), 8'h01);
        wakeLine = 1'b1;
        tick(8);
        check("wake", {1'b0, cfgOut}, 8'h00);
        check("wakeInt", {6'h00, oscSeen, serialOutLine}, 8'h02);
        wakeLine = 1'b0;
        tick(10);
        tally_and_finish();
    end
endmodule // tb_top
